//--- verilog/rcp_command_port.sv
/*
  Host command port of the recorder: nibble bus with write, read and
  chip select strobes, command sequencer, state word and busy timing.
  Assumes pins are asynchronous to clk_i; event inputs share clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module rcp_command_port #(
  parameter int unsigned CNT_W = 20,
  parameter int unsigned INIT_CYC = rcp_pkg::INIT_CYC,
  parameter int unsigned OSC_CYC = rcp_pkg::OSC_STABLE_CYC,
  parameter int unsigned MID_CYC = rcp_pkg::MID_CYC,
  parameter int unsigned LONG_CYC = rcp_pkg::LONG_CYC
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [3:0] data_i,
  output logic [3:0] data_o,
  output logic data_oe_o,
  input wire logic nwr_i,
  input wire logic nrd_i,
  input wire logic nce_i,
  input wire logic voice_seen_i,
  input wire logic mem_max_i,
  input wire logic flex_mode_i,
  input wire logic [3:0] readout_data_i,
  output logic nibble_stb_o,
  output logic [3:0] nibble_o,
  output logic halt_store_o
);

  localparam logic [19:0] RESET_CNT = 20'(INIT_CYC + OSC_CYC);

  // Pin synchronisers; only the second stage of each chain is read by logic.
  logic [1:0] wr_sync;
  logic [1:0] rd_sync;
  logic [1:0] ce_sync;
  logic [3:0] d_meta;
  logic [3:0] d_sync;
  logic wr_prev;
  logic rd_prev;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_sync <= 2'h3;
      rd_sync <= 2'h3;
      ce_sync <= 2'h3;
      d_meta <= 4'h0;
      d_sync <= 4'h0;
      wr_prev <= 1'b1;
      rd_prev <= 1'b1;
    end else begin
      wr_sync <= {wr_sync[0], nwr_i};
      rd_sync <= {rd_sync[0], nrd_i};
      ce_sync <= {ce_sync[0], nce_i};
      d_meta <= data_i;
      d_sync <= d_meta;
      wr_prev <= wr_sync[1];
      rd_prev <= rd_sync[1];
    end
  end

  // A nibble is taken on the falling write edge; chip select gates both.
  logic take;
  logic rd_done;
  assign take = wr_prev & ~wr_sync[1] & ~ce_sync[1]; // [R24]
  assign rd_done = ~rd_prev & rd_sync[1] & ~ce_sync[1];

  rcp_pkg::rcp_phase_t phase;
  rcp_pkg::rcp_phase_t next_phase;
  logic [2:0] cnt;
  logic [2:0] next_cnt;
  logic capture;
  logic next_capture;
  logic active;
  logic next_active;
  logic paused;
  logic next_paused;
  logic wait_voice;
  logic next_wait_voice;
  logic trig_en;
  logic next_trig_en;
  logic full;
  logic next_full;
  logic next_halt_store;
  logic next_nibble_stb;
  logic [3:0] next_nibble;
  logic [3:0] next_data_o;
  logic full_set;
  logic full_clr;
  logic do_halt;
  logic load;
  logic [CNT_W-1:0] load_cyc;
  logic load_flag;
  logic busy;
  logic processing;
  logic [3:0] state_word;

  rcp_busy_timer #(
    .CNT_W(CNT_W),
    .RESET_CNT(RESET_CNT)
  ) u_timer (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .load_i(load),
    .load_cnt_i(load_cyc),
    .load_flag_i(load_flag),
    .busy_o(busy),
    .flagged_o(processing)
  );

  // The state word; waiting covers both voice wait and pause.
  always_comb begin
    state_word = 4'h0;
    state_word[rcp_pkg::PROC_BIT] = processing; // [R03] [R11]
    state_word[rcp_pkg::ACTIVE_BIT] = active; // [R05]
    state_word[rcp_pkg::WAITING_BIT] = wait_voice | paused; // [R06] [R07]
    state_word[rcp_pkg::FULL_BIT] = full;
  end

  // Command sequencer. Nibbles arriving while busy are still taken, the
  // host is expected to keep off the bus until the flag drops.
  always_comb begin
    next_phase = phase;
    next_cnt = cnt;
    next_capture = capture;
    next_active = active;
    next_paused = paused;
    next_wait_voice = wait_voice;
    next_trig_en = trig_en;
    next_nibble_stb = 1'b0;
    next_nibble = nibble_o;
    full_clr = 1'b0;
    do_halt = 1'b0;
    load = 1'b0;
    load_cyc = CNT_W'(rcp_pkg::SHORT_CYC);
    load_flag = 1'b1;
    full_set = mem_max_i & active & capture & flex_mode_i; // [R08]
    // Voice heard while waiting starts the recording proper.
    if (wait_voice && voice_seen_i) begin
      next_wait_voice = 1'b0;
      next_active = 1'b1;
    end
    if (take) begin
      next_nibble_stb = 1'b1;
      next_nibble = d_sync;
      case (phase)
        rcp_pkg::RCP_PH_IDLE: begin
          load = 1'b1; // [R27]
          if (active || paused || wait_voice) begin
            // While running only halt, pause and resume are honoured.
            case (d_sync) // [R05]
              rcp_pkg::HALT_CMD: do_halt = 1'b1;
              rcp_pkg::PAUSE_CMD: begin
                if (active) begin
                  next_active = 1'b0;
                  next_paused = 1'b1; // [R07]
                end
              end
              rcp_pkg::BEGIN_CMD: begin
                full_clr = 1'b1; // [R09]
                if (paused) begin
                  next_paused = 1'b0;
                  next_active = 1'b1;
                end
              end
              default: load = 1'b0;
            endcase
          end else begin
            case (d_sync) // [R23]
              rcp_pkg::REPRODUCE_SELECT_CMD: begin
                next_capture = 1'b0;
                full_clr = 1'b1; // [R09]
              end
              rcp_pkg::CAPTURE_SELECT_CMD: begin
                next_capture = 1'b1;
                full_clr = 1'b1; // [R09]
              end
              rcp_pkg::BEGIN_CMD: begin
                full_clr = 1'b1; // [R09]
                if (capture && trig_en) begin
                  next_wait_voice = 1'b1; // [R06]
                end else begin
                  next_active = 1'b1;
                end
              end
              rcp_pkg::RATE_CFG_CMD,
              rcp_pkg::SLOT_SELECT_CMD,
              rcp_pkg::VOICE_DETECT_CFG_CMD: begin
                next_phase = rcp_pkg::RCP_PH_ARG;
              end
              rcp_pkg::INDEX_LOAD_CMD: begin
                next_phase = rcp_pkg::RCP_PH_LOAD;
                next_cnt = 3'h0;
                load_cyc = CNT_W'(LONG_CYC); // [R12]
              end
              rcp_pkg::INDEX_READOUT_CMD: begin
                next_phase = rcp_pkg::RCP_PH_READOUT;
                next_cnt = 3'h0;
                load_cyc = CNT_W'(LONG_CYC);
                load_flag = 1'b0; // [R14]
              end
              rcp_pkg::DIRECT_TRANSFER_CMD: begin
                next_phase = rcp_pkg::RCP_PH_DT_ADDR; // [R16]
                next_cnt = 3'h0;
              end
              rcp_pkg::BUS_STREAMED_CMD: begin
                next_phase = rcp_pkg::RCP_PH_STREAM; // [R22]
                next_active = 1'b1;
              end
              default: ;
            endcase
          end
        end
        rcp_pkg::RCP_PH_ARG: begin
          // The held opcode tells which setting the data nibble is for.
          load = 1'b1; // [R27]
          if (nibble_o == rcp_pkg::VOICE_DETECT_CFG_CMD) begin
            next_trig_en = |d_sync[1:0];
          end
          next_phase = rcp_pkg::RCP_PH_IDLE;
        end
        rcp_pkg::RCP_PH_LOAD: begin
          load = 1'b1;
          load_cyc = CNT_W'(MID_CYC); // [R13]
          next_cnt = cnt + 3'h1;
          if (cnt == rcp_pkg::INDEX_LAST) begin
            next_phase = rcp_pkg::RCP_PH_IDLE;
          end
        end
        rcp_pkg::RCP_PH_DT_ADDR: begin
          load = 1'b1; // [R16]
          next_cnt = cnt + 3'h1;
          if (cnt == rcp_pkg::DT_ADDR_LAST) begin
            load_cyc = CNT_W'(LONG_CYC); // [R17]
            next_phase = rcp_pkg::RCP_PH_DT_XFER;
          end
        end
        rcp_pkg::RCP_PH_DT_XFER: begin
          // Busy times here are fixed at the nominal sampling rate.
          load = 1'b1; // [R21]
          if (d_sync == rcp_pkg::HALT_CMD) begin
            load_cyc = CNT_W'(MID_CYC); // [R20]
            do_halt = 1'b1;
            next_phase = rcp_pkg::RCP_PH_IDLE;
          end else if (!active &&
                       d_sync == rcp_pkg::CAPTURE_SELECT_CMD) begin
            next_capture = 1'b1; // [R18]
            next_active = 1'b1;
          end else if (!active &&
                       d_sync == rcp_pkg::REPRODUCE_SELECT_CMD) begin
            next_capture = 1'b0;
            next_active = 1'b1;
            load_cyc = CNT_W'(MID_CYC);
            load_flag = 1'b0; // [R19]
          end else if (active && capture) begin
            load_cyc = CNT_W'(MID_CYC); // [R18]
          end else begin
            load = 1'b0;
          end
        end
        rcp_pkg::RCP_PH_STREAM: begin
          // Other nibbles are sample data for the codec, passed on only.
          if (d_sync == rcp_pkg::HALT_CMD) begin
            load = 1'b1;
            do_halt = 1'b1;
            next_phase = rcp_pkg::RCP_PH_IDLE;
          end
        end
        // Writes during readout are ignored so the sequence is not cut.
        rcp_pkg::RCP_PH_READOUT: ;
        default: next_phase = rcp_pkg::RCP_PH_IDLE;
      endcase
    end
    // Each finished readout nibble starts an unflagged gap.
    if (rd_done && phase == rcp_pkg::RCP_PH_READOUT) begin
      load = 1'b1;
      load_cyc = CNT_W'(MID_CYC);
      load_flag = 1'b0; // [R15]
      next_cnt = cnt + 3'h1;
      if (cnt == rcp_pkg::INDEX_LAST) begin
        next_phase = rcp_pkg::RCP_PH_IDLE;
      end
    end
    next_halt_store = do_halt & capture & (active | paused); // [R25]
    if (do_halt) begin
      next_active = 1'b0;
      next_paused = 1'b0;
      next_wait_voice = 1'b0;
    end
    // Reaching the memory end in the same cycle as a clear still sets.
    next_full = full_set ? 1'b1 : (full_clr ? 1'b0 : full); // [R08] [R09]
    // Readout nibbles replace the state word during the readout phase.
    if (phase == rcp_pkg::RCP_PH_READOUT) begin
      next_data_o = readout_data_i;
    end else begin
      next_data_o = state_word; // [R01]
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      phase <= rcp_pkg::RCP_PH_IDLE;
      cnt <= 3'h0;
      capture <= 1'b0;
      active <= 1'b0;
      paused <= 1'b0;
      wait_voice <= 1'b0;
      trig_en <= 1'b0;
      full <= 1'b0;
      halt_store_o <= 1'b0;
      nibble_stb_o <= 1'b0;
      nibble_o <= 4'h0;
      data_o <= 4'h0;
    end else begin
      phase <= next_phase;
      cnt <= next_cnt;
      capture <= next_capture;
      active <= next_active;
      paused <= next_paused;
      wait_voice <= next_wait_voice;
      trig_en <= next_trig_en;
      full <= next_full;
      halt_store_o <= next_halt_store;
      nibble_stb_o <= next_nibble_stb;
      nibble_o <= next_nibble;
      data_o <= next_data_o;
    end
  end

  // Drive the lines only for a selected read; never while streaming.
  assign data_oe_o = ~ce_sync[1] & ~rd_sync[1] &
                     (phase != rcp_pkg::RCP_PH_STREAM); // [R01] [R02] [R24]

  // Cycles since reset release, saturating, for the start-up check.
  logic [3:0] since_rst;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      since_rst <= 4'h0;
    end else if (since_rst != 4'hF) begin
      since_rst <= since_rst + 4'h1;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  // The pin reaches the gating after two flip-flops.
  property p_ce_release;
    $past(nce_i, 2) |-> !data_oe_o;
  endproperty
  a_ce_release: assert property (p_ce_release) // [R24]
    else $error("Data lines driven while chip select is high.");

  property p_stream_hides;
    take && phase == rcp_pkg::RCP_PH_STREAM &&
      d_sync != rcp_pkg::HALT_CMD
      |=> phase == rcp_pkg::RCP_PH_STREAM && !data_oe_o;
  endproperty
  a_stream_hides: assert property (p_stream_hides) // [R02]
    else $error("Sample nibble ended or exposed bus-streamed operation.");

  property p_startup_busy;
    (since_rst < 4'hE) |-> data_o[rcp_pkg::PROC_BIT] || since_rst == 4'h0;
  endproperty
  a_startup_busy: assert property (p_startup_busy) // [R11]
    else $error("Processing flag low during start-up interval.");

  property p_cmd_busy;
    take && phase == rcp_pkg::RCP_PH_IDLE && !active && !paused &&
      !wait_voice && d_sync == rcp_pkg::CAPTURE_SELECT_CMD
      |=> processing [*8] ##0 processing;
  endproperty
  a_cmd_busy: assert property (p_cmd_busy) // [R27]
    else $error("Command nibble did not give a flagged busy interval.");

  property p_readout_silent;
    take && phase == rcp_pkg::RCP_PH_IDLE && !active && !paused &&
      !wait_voice && d_sync == rcp_pkg::INDEX_READOUT_CMD
      |=> busy && !processing ##1 busy && !processing;
  endproperty
  a_readout_silent: assert property (p_readout_silent) // [R14]
    else $error("Readout opcode busy was flagged or missing.");

  property p_full_sets;
    full_set |=> full ##1 data_o[rcp_pkg::FULL_BIT];
  endproperty
  a_full_sets: assert property (p_full_sets) // [R08]
    else $error("Full flag not set at memory end.");

  property p_full_clears;
    take && phase == rcp_pkg::RCP_PH_IDLE && !full_set &&
      (d_sync == rcp_pkg::CAPTURE_SELECT_CMD ||
       d_sync == rcp_pkg::REPRODUCE_SELECT_CMD) |=> !full;
  endproperty
  a_full_clears: assert property (p_full_clears) // [R09]
    else $error("Full flag not cleared by a select command.");

  property p_running_ignores;
    take && active && phase == rcp_pkg::RCP_PH_IDLE &&
      (d_sync == rcp_pkg::RATE_CFG_CMD ||
       d_sync == rcp_pkg::SLOT_SELECT_CMD)
      |=> phase == rcp_pkg::RCP_PH_IDLE;
  endproperty
  a_running_ignores: assert property (p_running_ignores) // [R05]
    else $error("Configuration command accepted while running.");

  property p_pause_waits;
    paused |-> ##1 data_o[rcp_pkg::WAITING_BIT];
  endproperty
  a_pause_waits: assert property (p_pause_waits) // [R07]
    else $error("Waiting flag low while paused.");

  property p_halt_store;
    take && phase == rcp_pkg::RCP_PH_IDLE && active && capture &&
      d_sync == rcp_pkg::HALT_CMD |=> halt_store_o ##1 !halt_store_o;
  endproperty
  a_halt_store: assert property (p_halt_store) // [R25]
    else $error("Halt while recording gave no single stop-address store.");

endmodule
`default_nettype wire

//--- verilog/rcp_pkg.sv
/*
  Shared constants of the recorder host command port: opcodes, the
  layout of the operation state word and the busy interval lengths.
  Assumes a 100 MHz core clock; all cycle counts except OSC_STABLE_CYC derive from it.
*/
// Function
// R01: Four-bit state word is driven on the data lines during the read strobe.
// R02: No state word during index readout or bus-streamed recording or playback.
// R03: Processing flag high during reset start-up and while a nibble is handled.
// R04: Host sends no command while the processing flag reads high.
// R05: Active flag high while running; only halt, pause, begin accepted then.
// R06: Waiting flag high while a voice-triggered recording awaits voice.
// R07: Waiting flag high while running is suspended by pause.
// R08: In flex mode, full flag sets when recording reaches memory end.
// R09: Full flag clears on capture-select, reproduce-select or begin.
// R10: Host checks full flag before recording the next slot in flex mode.
// R11: After reset, processing stays high 125 us plus oscillator settling.
// R12: Index-load opcode gives a flagged 270 us busy interval.
// R13: Each index-load data nibble gives a flagged 50 us busy interval.
// R14: Index-readout opcode gives an unflagged 270 us busy; host times it.
// R15: Each index-readout nibble output gives an unflagged 50 us busy.
// R16: Direct transfer opcode, low and middle address nibbles give 16 us busy.
// R17: Direct transfer upper address nibble gives a 270 us busy interval.
// R18: In direct transfer, capture-select gives 16 us, write data 50 us.
// R19: In direct transfer, reproduce-select gives unflagged 50 us busy.
// R20: In direct transfer, the halt nibble gives a 50 us busy interval.
// R21: Flag valid in direct transfer only for write-only use; times scale. Code keeps the times fixed at the nominal rate.
// R22: Opcode 1011 streams samples over the nibble bus, no memory control.
// R23: Opcodes decode as listed, idle 0000 through voice-detect select 1100.
// R24: With chip select high, strobes are ignored and data lines released.
// R25: Halt while recording stores the address counter as the stop address.
// R26: Host polls processing flag to zero or waits the busy time first.
// R27: Each one-nibble command, two-nibble opcode and its data give 16 us.
package rcp_pkg;

  // Opcodes of the first nibble.
  localparam logic [3:0] IDLE_CMD = 4'h0; // [R23]
  localparam logic [3:0] PAUSE_CMD = 4'h1;
  localparam logic [3:0] REPRODUCE_SELECT_CMD = 4'h2;
  localparam logic [3:0] CAPTURE_SELECT_CMD = 4'h3;
  localparam logic [3:0] BEGIN_CMD = 4'h4;
  localparam logic [3:0] HALT_CMD = 4'h5;
  localparam logic [3:0] RATE_CFG_CMD = 4'h6;
  localparam logic [3:0] SLOT_SELECT_CMD = 4'h7;
  localparam logic [3:0] INDEX_LOAD_CMD = 4'h8;
  localparam logic [3:0] INDEX_READOUT_CMD = 4'h9;
  localparam logic [3:0] DIRECT_TRANSFER_CMD = 4'hA;
  localparam logic [3:0] BUS_STREAMED_CMD = 4'hB;
  localparam logic [3:0] VOICE_DETECT_CFG_CMD = 4'hC;

  // Bit positions inside the operation state word.
  localparam int unsigned PROC_BIT = 0;
  localparam int unsigned ACTIVE_BIT = 1;
  localparam int unsigned WAITING_BIT = 2;
  localparam int unsigned FULL_BIT = 3;

  // Nibbles that follow the index-load and index-readout opcodes.
  localparam logic [2:0] INDEX_LAST = 3'h7;
  // Address nibbles of a direct transfer, the last one being the upper.
  localparam logic [2:0] DT_ADDR_LAST = 3'h2;

  // Busy interval lengths in their own unit, and the clock period.
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned T_INIT_US = 125;
  localparam int unsigned T_SHORT_US = 16;
  localparam int unsigned T_MID_US = 50;
  localparam int unsigned T_LONG_US = 270;
  // Oscillator settling is board dependent; cycles, plain default.
  localparam int unsigned OSC_STABLE_CYC = 1000;

  // Least times round up to whole cycles.
  localparam int unsigned INIT_CYC =
    (T_INIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SHORT_CYC =
    (T_SHORT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MID_CYC =
    (T_MID_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned LONG_CYC =
    (T_LONG_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Phases of the command sequencer.
  typedef enum logic [2:0] {
    RCP_PH_IDLE = 3'b000,
    RCP_PH_ARG = 3'b001,
    RCP_PH_LOAD = 3'b010,
    RCP_PH_READOUT = 3'b011,
    RCP_PH_DT_ADDR = 3'b100,
    RCP_PH_DT_XFER = 3'b101,
    RCP_PH_STREAM = 3'b110
  } rcp_phase_t;

endpackage

//--- verilog/rcp_busy_timer.sv
/*
  Busy interval timer of the command port: counts a loaded number of
  cycles down and says whether the interval is shown in the state word.
  Assumes load requests come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module rcp_busy_timer #(
  parameter int unsigned CNT_W = 20,
  parameter logic [19:0] RESET_CNT = 20'h0
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic load_i,
  input wire logic [CNT_W-1:0] load_cnt_i,
  input wire logic load_flag_i,
  output logic busy_o,
  output logic flagged_o
);

  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic flag;
  logic next_flag;

  // A new load restarts the interval, even if one is still running.
  always_comb begin
    next_cnt = cnt;
    next_flag = flag;
    if (load_i) begin
      next_cnt = load_cnt_i;
      next_flag = load_flag_i;
    end else if (cnt != '0) begin
      next_cnt = cnt - 1'b1;
    end
  end

  // The start-up interval is loaded by reset itself, shown as flagged.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt <= RESET_CNT[CNT_W-1:0];
      flag <= 1'b1;
    end else begin
      cnt <= next_cnt;
      flag <= next_flag;
    end
  end

  // Busy stays high for exactly the loaded count of cycles.
  assign busy_o = (cnt != '0);
  assign flagged_o = busy_o & flag;

endmodule
`default_nettype wire

//--- test/rcp_host_model.sv
/*
  Host microcontroller model on the nibble bus: write, read, chip select.
  Assumes the testbench calls its tasks and shares the core clock.
*/
`timescale 1ns/1ps
`default_nettype none
module rcp_host_model (
  input wire logic clk_i,
  input wire logic [3:0] dev_data_i,
  input wire logic dev_oe_i,
  output logic [3:0] pins_o,
  output logic nwr_o,
  output logic nrd_o,
  output logic nce_o
);
  logic drv = 1'b0;
  logic [3:0] wdat = 4'h0;
  // A released bus shows the inverse of the last nibble, never a stale copy.
  assign pins_o = dev_oe_i ? dev_data_i : (drv ? wdat : ~wdat);

  // Strobes idle high, chip selected.
  initial begin
    nwr_o = 1'b1;
    nrd_o = 1'b1;
    nce_o = 1'b0;
  end

  task automatic set_cs(input logic v);
    @(posedge clk_i);
    nce_o <= v;
  endtask

  // Data is steady well around the strobe since the pins are synced.
  task automatic write_nib(input logic [3:0] v);
    @(posedge clk_i);
    drv <= 1'b1;
    wdat <= v;
    repeat (3) @(posedge clk_i);
    nwr_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    nwr_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    drv <= 1'b0;
  endtask

  // Holds the read strobe while the processing flag is high, up to lim.
  task automatic read_poll(input int lim, output int cyc,
                           output logic [3:0] st, output logic oe);
    cyc = 0;
    @(posedge clk_i);
    nrd_o <= 1'b0;
    repeat (3) @(posedge clk_i);
    oe = dev_oe_i;
    st = dev_data_i;
    while (dev_oe_i === 1'b1 && dev_data_i[0] === 1'b1 && cyc < lim) begin
      @(posedge clk_i);
      cyc++;
      st = dev_data_i;
    end
    nrd_o <= 1'b1;
    repeat (3) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

//--- test/testbench.sv
/*
  Self-checking testbench of the command port driven by a host model.
  Assumes shortened busy parameters; command busy stays SHORT_CYC.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int INIT = 20;
  localparam int OSC = 5;
  localparam int MID = 30;
  localparam int LONG = 60;
  localparam int SHORT = rcp_pkg::SHORT_CYC;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic voice = 1'b0;
  logic mmax = 1'b0;
  logic flex = 1'b0;
  logic [3:0] rdat = 4'h0;
  logic [3:0] pins, dout, nib, st;
  logic oe, nwr, nrd, nce, stb, hstore, seen_oe;
  int miscompares = 0;
  int n_compared = 0;
  int stores = 0;
  int strobes = 0;
  int cyc;

  // Core clock.
  always #5 clk_i = ~clk_i;
  // Stop-address store pulses are counted for the halt scenario.
  always @(posedge clk_i) if (hstore === 1'b1) stores++;
  // Nibble strobes are counted for the streaming scenario.
  always @(posedge clk_i) if (stb === 1'b1) strobes++;

  rcp_command_port #(.INIT_CYC(INIT), .OSC_CYC(OSC), .MID_CYC(MID),
    .LONG_CYC(LONG)) dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .data_i(pins),
    .data_o(dout), .data_oe_o(oe), .nwr_i(nwr), .nrd_i(nrd), .nce_i(nce),
    .voice_seen_i(voice), .mem_max_i(mmax), .flex_mode_i(flex),
    .readout_data_i(rdat), .nibble_stb_o(stb), .nibble_o(nib),
    .halt_store_o(hstore));
  rcp_host_model host_u (.clk_i(clk_i), .dev_data_i(dout), .dev_oe_i(oe),
    .pins_o(pins), .nwr_o(nwr), .nrd_o(nrd), .nce_o(nce));

  task automatic check(input string what, input logic [31:0] got,
                       input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // Bus overhead off shifts the count, so a margin of 8 cycles either way is allowed.
  task automatic busy(input string what, input int off, input int n);
    host_u.read_poll(n + 40, cyc, st, seen_oe);
    check(what, (cyc + off >= n - 8) && (cyc + off <= n + 8), 1'b1);
  endtask

  task automatic wr(input logic [3:0] v);
    host_u.write_nib(v);
    busy("cmd busy", 8, SHORT);
  endtask

  task automatic rd;
    host_u.read_poll(0, cyc, st, seen_oe);
  endtask

  task automatic t_run;
    wr(rcp_pkg::RATE_CFG_CMD);
    wr(4'h3);
    wr(rcp_pkg::REPRODUCE_SELECT_CMD);
    wr(rcp_pkg::BEGIN_CMD);
    check("active", st[1], 1'b1);
    check("nibble", nib, rcp_pkg::BEGIN_CMD);
    host_u.write_nib(rcp_pkg::SLOT_SELECT_CMD);
    rd();
    check("refused", st[0], 1'b0);
    wr(rcp_pkg::HALT_CMD);
    check("halted", st[1], 1'b0);
    $display("test run done");
  endtask

  task automatic t_voice;
    flex <= 1'b1;
    wr(rcp_pkg::VOICE_DETECT_CFG_CMD);
    wr(4'h1);
    wr(rcp_pkg::CAPTURE_SELECT_CMD);
    wr(rcp_pkg::BEGIN_CMD);
    check("wait voice", st[3:1], 3'b010);
    voice <= 1'b1;
    rd();
    check("voice run", st[3:1], 3'b001);
    mmax <= 1'b1;
    @(posedge clk_i);
    mmax <= 1'b0;
    wr(rcp_pkg::PAUSE_CMD);
    check("paused full", st[3:2], 2'b11);
    wr(rcp_pkg::BEGIN_CMD);
    check("resumed", st[3:1], 3'b001);
    mmax <= 1'b1;
    @(posedge clk_i);
    mmax <= 1'b0;
    wr(rcp_pkg::HALT_CMD);
    check("stop store", stores, 1);
    check("full kept", st[3], 1'b1);
    voice <= 1'b0;
    $display("test voice done");
  endtask

  task automatic t_index;
    host_u.write_nib(rcp_pkg::INDEX_LOAD_CMD);
    busy("load busy", 8, LONG);
    for (int i = 0; i < 8; i++) begin
      host_u.write_nib(i[3:0]);
      busy("load nibble", 8, MID);
    end
    host_u.write_nib(rcp_pkg::INDEX_READOUT_CMD);
    repeat (LONG) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      rdat <= 4'hF - i[3:0];
      rd();
      check("readout", st, 4'hF - i[3:0]);
      repeat (MID) @(posedge clk_i);
    end
    $display("test index done");
  endtask

  task automatic t_dt;
    int n [7] = '{SHORT, SHORT, SHORT, LONG, SHORT, MID, MID};
    logic [3:0] v [7] = '{4'hA, 4'h1, 4'h2, 4'h3, 4'h3, 4'h7, 4'h5};
    for (int i = 0; i < 7; i++) begin
      host_u.write_nib(v[i]);
      busy("transfer", 8, n[i]);
    end
    // Second pass plays back; its reproduce-select busy is unflagged and must be timed.
    for (int i = 0; i < 4; i++) begin
      host_u.write_nib(v[i]);
      busy("transfer again", 8, n[i]);
    end
    host_u.write_nib(rcp_pkg::REPRODUCE_SELECT_CMD);
    rd();
    check("reproduce_select_cmd unflagged", st[1:0], 2'b10);
    repeat (MID) @(posedge clk_i);
    host_u.write_nib(rcp_pkg::HALT_CMD);
    busy("transfer halt", 8, MID);
    $display("test transfer done");
  endtask

  task automatic t_stream;
    int s0;
    host_u.write_nib(rcp_pkg::BUS_STREAMED_CMD);
    repeat (SHORT + 10) @(posedge clk_i);
    rd();
    check("stream oe", seen_oe, 1'b0);
    s0 = strobes;
    host_u.write_nib(4'h6);
    check("stream strobe", strobes - s0, 1);
    check("stream nibble", nib, 4'h6);
    host_u.write_nib(rcp_pkg::HALT_CMD);
    busy("stream halt", 8, SHORT);
    check("stream end", st[1], 1'b0);
    host_u.set_cs(1'b1);
    rd();
    check("cs oe", seen_oe, 1'b0);
    host_u.write_nib(rcp_pkg::BEGIN_CMD);
    host_u.set_cs(1'b0);
    rd();
    check("cs ignored", st[1:0], 2'b00);
    $display("test stream done");
  endtask

  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Main sequence: reset for two cycles, then each scenario in turn.
  initial begin
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    busy("reset busy", 4, INIT + OSC);
    t_run();
    t_voice();
    t_index();
    t_dt();
    t_stream();
    give_verdict();
  end

  // Watchdog well beyond the roughly 35000 cycles the scenarios need.
  initial begin
    repeat (90000) @(posedge clk_i);
    miscompares++;
    give_verdict();
  end
endmodule
`default_nettype wire
